// ---- src/dqx_acq_ctl.sv ----
// Acquisition timing, interrupts and chained DMA for the analog input
`timescale 1ns/1ps
module dqx_acq_ctl (
  input wire logic CLK,
  input wire logic RST,
  input wire logic EXT_TRIGGER_IN,
  input wire logic EXT_CONVERT_STROBE_N,
  input wire logic SCAN_PULSE_PIN,
  input wire logic SOFT_TRIGGER_BIT,
  input wire logic HARD_TRIGGER_ENABLE,
  input wire logic EXT_CONVERT_DISABLE,
  input wire logic PRETRIGGER_SELECT,
  input wire logic INTERVAL_SCAN_ENABLE,
  input wire logic EXT_SCAN_RECEIVE,
  input wire logic [7:0] COUNTER_A_MODE,
  input wire logic COUNTER_A_MODE_WR,
  input wire logic SAMPLE_COUNTER_OUT,
  input wire logic [15:0] SAMPLE_COUNT_N,
  input wire logic SCAN_COUNTER_OUT,
  input wire logic [7:0] SCAN_SAMPLES,
  input wire logic FIFO_CLEAR_WR,
  input wire logic ADC_DONE,
  input wire logic [dqx_pkg::DATA_W-1:0] ADC_DATA,
  output logic ADC_START,
  input wire logic FIFO_READ,
  output logic [dqx_pkg::DATA_W-1:0] FIFO_DATA,
  input wire logic FIFO_DATA_IRQ_ENABLE,
  input wire logic HALF_FULL_IRQ_ENABLE,
  input wire logic ERROR_IRQ_ENABLE,
  input wire logic ACQ_END_IRQ_ENABLE,
  input wire logic DMA_REQUEST_ENABLE,
  input wire logic FLAG_CLEAR,
  output logic DATA_AVAILABLE_FLAG,
  output logic FIFO_HALF_FULL_N,
  output logic OVERFLOW_FLAG,
  output logic OVERRUN_FLAG,
  output logic COUNT_COUNTER_OUT,
  output logic ACQ_RUNNING,
  output logic IRQ,
  output logic DMA_REQUEST,
  input wire logic [dqx_pkg::ADDR_W-1:0] NEXT_LINK_ADDRESS,
  input wire logic DMA_ARM,
  output logic DMA_BUSY,
  output logic MEM_RD,
  output logic [dqx_pkg::ADDR_W-1:0] MEM_RD_ADDR,
  input wire logic MEM_RD_VALID,
  input wire logic [dqx_pkg::ADDR_W-1:0] MEM_RD_DATA,
  output logic MEM_WR,
  output logic [dqx_pkg::ADDR_W-1:0] MEM_WR_ADDR,
  output logic [dqx_pkg::DATA_W-1:0] MEM_WR_DATA,
  input wire logic MEM_WR_READY
);
  import dqx_pkg::*;

  dqx_stream_if #(.W(DATA_W)) in_s ();
  dqx_stream_if #(.W(DATA_W)) out_s ();

  dqx_acq_t acq_reg, acq_next;
  dqx_dma_t dma_reg, dma_next;
  logic trig_d_reg, strobe_d_reg, samp_d_reg, scan_d_reg, soft_d_reg;
  logic forced_high_reg, skip_first_reg, busy_reg, have_word_reg;
  logic [13:0] busy_cnt_reg;
  logic [16:0] left_reg;
  logic [7:0] scan_left_reg;
  logic [CAP_W-1:0] occ_reg;
  logic [$clog2(FIFO_DEPTH):0] lvl;
  logic [ADDR_W-1:0] link_reg, buf_reg, bytes_reg, desc_reg [DESC_WORDS];
  logic [1:0] widx_reg;
  logic [DATA_W-1:0] word_reg;

  // Edge detectors on the pins
  wire trig_rise = EXT_TRIGGER_IN && !trig_d_reg;
  wire strobe_fall = !EXT_CONVERT_STROBE_N && strobe_d_reg;
  wire samp_fall = !SAMPLE_COUNTER_OUT && samp_d_reg;
  wire scan_rise = SCAN_PULSE_PIN && !scan_d_reg;
  wire int_scan_rise = SCAN_COUNTER_OUT && !scan_d_reg;
  wire use_ext_conv = forced_high_reg && !EXT_CONVERT_DISABLE;
  wire ext_scan = INTERVAL_SCAN_ENABLE && EXT_SCAN_RECEIVE;
  wire scan_tick = ext_scan ? scan_rise : int_scan_rise;
  wire scan_ok = !INTERVAL_SCAN_ENABLE || (scan_left_reg != 8'h00);
  wire pace = use_ext_conv ? (strobe_fall && !skip_first_reg)
                           : samp_fall;
  wire counting = (acq_reg == ACQ_RUN) && (left_reg != '0);
  wire conv_go = (acq_reg != ACQ_IDLE) && pace && scan_ok
    && (acq_reg == ACQ_ARMED ? PRETRIGGER_SELECT : counting);
  // Soft start is an edge, so a held bit cannot relaunch after count out
  wire start_sw = SOFT_TRIGGER_BIT && !soft_d_reg && !HARD_TRIGGER_ENABLE;
  wire start_hw = HARD_TRIGGER_ENABLE && trig_rise && !PRETRIGGER_SELECT;
  wire full_cap = (occ_reg == CAP_W'(SAMPLE_CAP));
  wire take_host = FIFO_READ && out_s.valid && !DMA_BUSY;

  // Counter A mode write of the rate code holds the sample output high
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) forced_high_reg <= 1'b0;
    else if (COUNTER_A_MODE_WR)
      forced_high_reg <= (COUNTER_A_MODE == MODE_A0_RATE);
  end

  // Pin history for edge detection
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      trig_d_reg <= 1'b0;
      strobe_d_reg <= 1'b1;
      samp_d_reg <= 1'b0;
      scan_d_reg <= 1'b0;
      soft_d_reg <= 1'b0;
    end else begin
      soft_d_reg <= SOFT_TRIGGER_BIT;
      trig_d_reg <= EXT_TRIGGER_IN;
      strobe_d_reg <= EXT_CONVERT_STROBE_N;
      samp_d_reg <= SAMPLE_COUNTER_OUT;
      scan_d_reg <= ext_scan ? SCAN_PULSE_PIN : SCAN_COUNTER_OUT;
    end
  end

  // Acquisition sequencer; armed state only sees the trigger once
  always_comb begin
    acq_next = acq_reg;
    case (acq_reg)
      ACQ_IDLE: begin
        if (start_sw && PRETRIGGER_SELECT) acq_next = ACQ_ARMED;
        else if (start_sw || start_hw) acq_next = ACQ_RUN;
      end
      ACQ_ARMED: begin
        if (!SOFT_TRIGGER_BIT) acq_next = ACQ_IDLE;
        else if (trig_rise) acq_next = ACQ_RUN;
      end
      ACQ_RUN: begin
        if (left_reg == '0) acq_next = ACQ_IDLE;
        else if (!SOFT_TRIGGER_BIT && !HARD_TRIGGER_ENABLE)
          acq_next = ACQ_IDLE;
      end
      default: acq_next = ACQ_IDLE;
    endcase
  end

  // Posttrigger runs N + 2, pretrigger N + 1 after the edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acq_reg <= ACQ_IDLE;
      left_reg <= '0;
    end else begin
      acq_reg <= acq_next;
      if (acq_reg != ACQ_RUN && acq_next == ACQ_RUN)
        left_reg <= PRETRIGGER_SELECT ? 17'(SAMPLE_COUNT_N) + 17'h1
                                      : 17'(SAMPLE_COUNT_N) + 17'h2;
      else if (conv_go && acq_reg == ACQ_RUN)
        left_reg <= 17'(left_reg - 1'b1);
    end
  end

  // First strobe after a start straight from idle into run (not via armed) is dropped to keep timing deterministic
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) skip_first_reg <= 1'b0;
    else if (acq_reg == ACQ_IDLE && acq_next == ACQ_RUN)
      skip_first_reg <= 1'b1;
    else if (strobe_fall) skip_first_reg <= 1'b0;
  end

  // Samples per scan interval, reloaded on each scan pulse
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) scan_left_reg <= 8'h00;
    else if (scan_tick) scan_left_reg <= SCAN_SAMPLES;
    else if (conv_go && INTERVAL_SCAN_ENABLE)
      scan_left_reg <= 8'(scan_left_reg - 1'b1);
  end

  // Converter busy window; a start inside it is an overrun
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (conv_go && !busy_reg) begin
      busy_reg <= 1'b1;
      busy_cnt_reg <= 14'(CONV_CYCLES);
    end else if (busy_reg && (ADC_DONE || busy_cnt_reg == 14'h1)) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      busy_cnt_reg <= 14'(busy_cnt_reg - 1'b1);
    end
  end
  assign ADC_START = conv_go && !busy_reg;

  // Results enter the small FIFO; occupancy models the full store
  assign in_s.valid = busy_reg && ADC_DONE && !full_cap;
  assign in_s.data = ADC_DATA;

  dqx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .flush(FIFO_CLEAR_WR),
    .wr(in_s),
    .rd(out_s),
    .level(lvl)
  );

  // Consumer side: host reads or DMA moves drain the FIFO
  wire dma_take = (dma_reg == DMA_MOVE) && !have_word_reg && out_s.valid;
  assign out_s.ready = take_host || dma_take;

  // Stored count for half-full; clear empties it in one step
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) occ_reg <= '0;
    else if (FIFO_CLEAR_WR) occ_reg <= '0;
    else
      occ_reg <= CAP_W'(occ_reg + (in_s.valid && in_s.ready)
        - (out_s.valid && out_s.ready));
  end

  // Sticky error flags: a new event beats a clear in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OVERFLOW_FLAG <= 1'b0;
      OVERRUN_FLAG <= 1'b0;
    end else begin
      if (busy_reg && ADC_DONE && (!in_s.ready || full_cap))
        OVERFLOW_FLAG <= 1'b1;
      else if (FLAG_CLEAR) OVERFLOW_FLAG <= 1'b0;
      if (conv_go && busy_reg) OVERRUN_FLAG <= 1'b1;
      else if (FLAG_CLEAR) OVERRUN_FLAG <= 1'b0;
    end
  end

  // Status flags and host read data
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DATA_AVAILABLE_FLAG <= 1'b0;
      FIFO_HALF_FULL_N <= 1'b1;
      COUNT_COUNTER_OUT <= 1'b0;
      FIFO_DATA <= '0;
    end else begin
      DATA_AVAILABLE_FLAG <= (lvl != '0);
      FIFO_HALF_FULL_N <= (occ_reg < CAP_W'(HALF_MARK));
      if (acq_next == ACQ_RUN && acq_reg != ACQ_RUN)
        COUNT_COUNTER_OUT <= 1'b0;
      else if (acq_reg == ACQ_RUN && left_reg == '0)
        COUNT_COUNTER_OUT <= 1'b1;
      if (take_host) FIFO_DATA <= out_s.data;
    end
  end
  assign ACQ_RUNNING = (acq_reg != ACQ_IDLE);

  // Interrupt line is an OR of the four gated sources
  wire irq_data = FIFO_DATA_IRQ_ENABLE && DATA_AVAILABLE_FLAG;
  wire irq_half = HALF_FULL_IRQ_ENABLE && !FIFO_HALF_FULL_N;
  wire irq_err = ERROR_IRQ_ENABLE
    && (OVERFLOW_FLAG || OVERRUN_FLAG);
  wire irq_end = ACQ_END_IRQ_ENABLE && COUNT_COUNTER_OUT;
  assign IRQ = irq_data || irq_half || irq_err || irq_end;
  assign DMA_REQUEST = DMA_REQUEST_ENABLE && out_s.valid;

  // Chain walker: fetch four words, stop on an all-zero descriptor
  wire desc_zero = (desc_reg[0] | desc_reg[1] | desc_reg[2]
    | desc_reg[3]) == '0;
  always_comb begin
    dma_next = dma_reg;
    case (dma_reg)
      DMA_IDLE: if (DMA_ARM) dma_next = DMA_FETCH;
      DMA_FETCH:
        if (MEM_RD_VALID && widx_reg == DW_LINK) dma_next = DMA_CHECK;
      DMA_CHECK: dma_next = desc_zero ? DMA_DONE : DMA_MOVE;
      DMA_MOVE:
        if (bytes_reg == '0) dma_next = DMA_FETCH;
      DMA_DONE: dma_next = DMA_IDLE;
      default: dma_next = DMA_IDLE;
    endcase
  end
  assign DMA_BUSY = (dma_reg != DMA_IDLE);
  assign MEM_RD = (dma_reg == DMA_FETCH);
  assign MEM_RD_ADDR = ADDR_W'(link_reg + {widx_reg, 2'b00});
  assign MEM_WR = (dma_reg == DMA_MOVE) && have_word_reg;
  assign MEM_WR_ADDR = buf_reg;
  assign MEM_WR_DATA = word_reg;

  // Descriptor words in order: count, buffer, device, next link
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dma_reg <= DMA_IDLE;
      widx_reg <= DW_COUNT;
      link_reg <= '0;
      buf_reg <= '0;
      bytes_reg <= '0;
      have_word_reg <= 1'b0;
      word_reg <= '0;
      for (int i = 0; i < DESC_WORDS; i++) desc_reg[i] <= '0;
    end else begin
      dma_reg <= dma_next;
      if (dma_reg == DMA_IDLE && DMA_ARM) begin
        link_reg <= NEXT_LINK_ADDRESS;
        widx_reg <= DW_COUNT;
      end
      if (dma_reg == DMA_FETCH && MEM_RD_VALID) begin
        desc_reg[widx_reg] <= MEM_RD_DATA;
        widx_reg <= 2'(widx_reg + 1'b1);
      end
      if (dma_reg == DMA_CHECK) begin
        bytes_reg <= desc_reg[DW_COUNT];
        buf_reg <= desc_reg[DW_BUF];
        link_reg <= desc_reg[DW_LINK];
      end
      if (dma_take) begin
        word_reg <= out_s.data;
        have_word_reg <= 1'b1;
      end else if (MEM_WR && MEM_WR_READY) begin
        have_word_reg <= 1'b0;
        buf_reg <= ADDR_W'(buf_reg + 32'h2);
        bytes_reg <= (bytes_reg > 32'h2) ? ADDR_W'(bytes_reg - 32'h2)
                                         : '0;
      end
    end
  end


  // Checks on sequencing, flags and the chain walker
  a_hw_once: assert property (@(posedge CLK) disable iff (RST)
    (acq_reg == ACQ_RUN && HARD_TRIGGER_ENABLE && trig_rise)
    |=> acq_reg != ACQ_ARMED)
    else $error("trigger edge disturbed a running acquisition");
  a_clear_empties: assert property (@(posedge CLK) disable iff (RST)
    FIFO_CLEAR_WR |=> occ_reg == '0 && lvl == '0)
    else $error("fifo clear left data");
  a_stop_count: assert property (@(posedge CLK) disable iff (RST)
    (acq_reg == ACQ_RUN && left_reg == '0) |=> acq_reg == ACQ_IDLE)
    else $error("acquisition ran past its count");
  a_pre_load: assert property (@(posedge CLK) disable iff (RST)
    (acq_reg == ACQ_ARMED && acq_next == ACQ_RUN)
    |=> left_reg == 17'(SAMPLE_COUNT_N) + 17'h1)
    else $error("pretrigger count not N plus one");
  a_irq_or: assert property (@(posedge CLK) disable iff (RST)
    (ERROR_IRQ_ENABLE && $rose(OVERRUN_FLAG)) |-> IRQ)
    else $error("error interrupt missing");
  a_dma_req: assert property (@(posedge CLK) disable iff (RST)
    DMA_REQUEST |-> DMA_REQUEST_ENABLE && DATA_AVAILABLE_FLAG
      || $past(lvl) == '0)
    else $error("dma request without data");
  a_overrun: assert property (@(posedge CLK) disable iff (RST)
    (conv_go && busy_reg) |=> OVERRUN_FLAG)
    else $error("overrun not flagged");
  a_zero_stop: assert property (@(posedge CLK) disable iff (RST)
    (dma_reg == DMA_CHECK && desc_zero) |=> ##1 dma_reg == DMA_IDLE)
    else $error("chain did not stop on empty node");
  a_end_flag: assert property (@(posedge CLK) disable iff (RST)
    (acq_reg == ACQ_RUN && left_reg == '0) |=> COUNT_COUNTER_OUT)
    else $error("count output not set at end");
  a_skip_first: assert property (@(posedge CLK) disable iff (RST)
    (acq_reg == ACQ_IDLE && acq_next == ACQ_RUN) |=> skip_first_reg)
    else $error("first strobe not marked for dropping");
endmodule // dqx_acq_ctl

// ---- src/dqx_pkg.sv ----
// Package with constants and types for the acquisition control block
package dqx_pkg;
  localparam int DATA_W = 12;
  localparam int ADDR_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int SAMPLE_CAP = 4096;
  localparam int HALF_MARK = 2048;
  localparam int CAP_W = 13;
  localparam logic [7:0] MODE_A0_RATE = 8'h34;
  localparam int CONV_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int DESC_WORDS = 4;
  localparam logic [1:0] DW_COUNT = 2'h0;
  localparam logic [1:0] DW_BUF = 2'h1;
  localparam logic [1:0] DW_DEV = 2'h2;
  localparam logic [1:0] DW_LINK = 2'h3;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_ARMED, ACQ_RUN} dqx_acq_t;
  typedef enum logic [2:0] {DMA_IDLE, DMA_FETCH, DMA_CHECK, DMA_MOVE,
    DMA_DONE} dqx_dma_t;
endpackage

// ---- src/dqx_stream_if.sv ----
// Interface carrying a valid/ready sample stream between modules
`timescale 1ns/1ps
interface dqx_stream_if #(parameter int W = 12);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface // dqx_stream_if

// ---- src/dqx_fifo.sv ----
// Small valid/ready FIFO in the sample path
`timescale 1ns/1ps
module dqx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  dqx_stream_if.dst wr,
  dqx_stream_if.src rd,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_reg, rp_reg;
  logic [PW:0] cnt_reg;
  wire do_wr = wr.valid && wr.ready;
  wire do_rd = rd.valid && rd.ready;
  // Full and empty come from the counter, never from pointer guesses
  assign wr.ready = (cnt_reg != (PW+1)'(DEPTH)) && !flush;
  assign rd.valid = (cnt_reg != '0);
  assign rd.data = mem[rp_reg];
  assign level = cnt_reg;
  // Storage has no reset, only the pointers and the count need it
  always_ff @(posedge clk) begin
    if (do_wr) mem[wp_reg] <= wr.data;
  end
  // Flush wins over reads and writes so a clear empties it in one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) wp_reg <= PW'(wp_reg + 1'b1);
      if (do_rd) rp_reg <= PW'(rp_reg + 1'b1);
      cnt_reg <= (PW+1)'(cnt_reg + do_wr - do_rd);
    end
  end
  a_no_overfill: assert property (@(posedge clk) disable iff (rst)
    cnt_reg <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // dqx_fifo

// ---- sim/dqx_far_model.sv ----
// Far-side model: converter, descriptor memory and buffer memory
`timescale 1ns/1ps
module dqx_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] adc_lat,
  input wire logic [1:0] mem_lat,
  input wire logic adc_start,
  output logic adc_done,
  output logic [dqx_pkg::DATA_W-1:0] adc_data,
  input wire logic mem_rd,
  input wire logic [dqx_pkg::ADDR_W-1:0] mem_rd_addr,
  output logic mem_rd_valid,
  output logic [dqx_pkg::ADDR_W-1:0] mem_rd_data,
  input wire logic mem_wr,
  input wire logic [dqx_pkg::ADDR_W-1:0] mem_wr_addr,
  output logic mem_wr_ready,
  output int wr_count,
  output logic [dqx_pkg::ADDR_W-1:0] wr_last
);
  import dqx_pkg::*;
  logic [ADDR_W-1:0] desc_mem [16];
  logic [ADDR_W-1:0] rd_word;
  logic [DATA_W-1:0] seq;
  logic tog;
  int adc_cnt;
  int rd_cnt;
  int wr_cnt;
  // Two descriptors of four words; the second is all zero to end it
  initial begin
    foreach (desc_mem[i]) desc_mem[i] = 32'h0;
    desc_mem[0] = 32'h4;
    desc_mem[1] = 32'h100;
    desc_mem[3] = 32'h10;
  end
  // Idle buses toggle so a stale value can never pass for a real one
  assign adc_data = adc_done ? seq : {DATA_W{tog}};
  assign mem_rd_data = mem_rd_valid ? rd_word : {ADDR_W{tog}};
  // Converter busy for adc_lat cycles; a start while busy is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_cnt <= 0;
      seq <= 12'h000;
      adc_done <= 1'b0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      adc_done <= 1'b0;
      if (adc_cnt == 1) begin
        adc_done <= 1'b1;
        seq <= seq + 12'h001;
      end
      if (adc_cnt > 0) adc_cnt <= adc_cnt - 1;
      else if (adc_start) adc_cnt <= int'(adc_lat);
    end
  end
  // Memory answers reads and writes after mem_lat idle cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rd_valid <= 1'b0;
      mem_wr_ready <= 1'b0;
      rd_cnt <= 0;
      wr_cnt <= 0;
      wr_count <= 0;
      wr_last <= 32'h0;
      rd_word <= 32'h0;
    end else begin
      mem_rd_valid <= 1'b0;
      mem_wr_ready <= 1'b0;
      if (mem_rd && !mem_rd_valid) begin
        rd_cnt <= (rd_cnt >= int'(mem_lat)) ? 0 : rd_cnt + 1;
        mem_rd_valid <= rd_cnt >= int'(mem_lat);
        rd_word <= desc_mem[mem_rd_addr[5:2]];
      end
      if (mem_wr && mem_wr_ready) begin
        wr_count <= wr_count + 1;
        wr_last <= mem_wr_addr;
      end else if (mem_wr) begin
        wr_cnt <= (wr_cnt >= int'(mem_lat)) ? 0 : wr_cnt + 1;
        mem_wr_ready <= wr_cnt >= int'(mem_lat);
      end
    end
  end
endmodule // dqx_far_model

// ---- sim/dqx_acq_ctl_tb.sv ----
// Self-checking bench for the acquisition control block
`timescale 1ns/1ps
module dqx_acq_ctl_tb;
  import dqx_pkg::*;
  logic CLK, RST, EXT_TRIGGER_IN, EXT_CONVERT_STROBE_N, SCAN_PULSE_PIN;
  logic SOFT_TRIGGER_BIT, HARD_TRIGGER_ENABLE, EXT_CONVERT_DISABLE;
  logic PRETRIGGER_SELECT, INTERVAL_SCAN_ENABLE, EXT_SCAN_RECEIVE;
  logic COUNTER_A_MODE_WR, SAMPLE_COUNTER_OUT, SCAN_COUNTER_OUT;
  logic FIFO_CLEAR_WR, ADC_DONE, ADC_START, FIFO_READ, FLAG_CLEAR;
  logic FIFO_DATA_IRQ_ENABLE, HALF_FULL_IRQ_ENABLE, ERROR_IRQ_ENABLE;
  logic ACQ_END_IRQ_ENABLE, DMA_REQUEST_ENABLE, DMA_ARM, DMA_BUSY;
  logic DATA_AVAILABLE_FLAG, FIFO_HALF_FULL_N, OVERFLOW_FLAG, OVERRUN_FLAG;
  logic COUNT_COUNTER_OUT, ACQ_RUNNING, IRQ, DMA_REQUEST;
  logic MEM_RD, MEM_RD_VALID, MEM_WR, MEM_WR_READY, auto_rd, rd_d;
  logic [7:0] COUNTER_A_MODE, SCAN_SAMPLES, adc_lat;
  logic [15:0] SAMPLE_COUNT_N;
  logic [1:0] mem_lat;
  logic [DATA_W-1:0] ADC_DATA, FIFO_DATA, MEM_WR_DATA;
  logic [ADDR_W-1:0] NEXT_LINK_ADDRESS, MEM_RD_ADDR, MEM_RD_DATA;
  logic [ADDR_W-1:0] MEM_WR_ADDR, wr_last;
  logic [DATA_W-1:0] got [$];
  int err_total, checks_done, starts, wr_count, s0, i, n;

  dqx_acq_ctl uut (.CLK, .RST, .EXT_TRIGGER_IN, .EXT_CONVERT_STROBE_N,
    .SCAN_PULSE_PIN, .SOFT_TRIGGER_BIT, .HARD_TRIGGER_ENABLE,
    .EXT_CONVERT_DISABLE, .PRETRIGGER_SELECT, .INTERVAL_SCAN_ENABLE,
    .EXT_SCAN_RECEIVE, .COUNTER_A_MODE, .COUNTER_A_MODE_WR,
    .SAMPLE_COUNTER_OUT, .SAMPLE_COUNT_N, .SCAN_COUNTER_OUT, .SCAN_SAMPLES,
    .FIFO_CLEAR_WR, .ADC_DONE, .ADC_DATA, .ADC_START, .FIFO_READ, .FIFO_DATA,
    .FIFO_DATA_IRQ_ENABLE, .HALF_FULL_IRQ_ENABLE, .ERROR_IRQ_ENABLE,
    .ACQ_END_IRQ_ENABLE, .DMA_REQUEST_ENABLE, .FLAG_CLEAR,
    .DATA_AVAILABLE_FLAG, .FIFO_HALF_FULL_N, .OVERFLOW_FLAG, .OVERRUN_FLAG,
    .COUNT_COUNTER_OUT, .ACQ_RUNNING, .IRQ, .DMA_REQUEST, .NEXT_LINK_ADDRESS,
    .DMA_ARM, .DMA_BUSY, .MEM_RD, .MEM_RD_ADDR, .MEM_RD_VALID, .MEM_RD_DATA,
    .MEM_WR, .MEM_WR_ADDR, .MEM_WR_DATA, .MEM_WR_READY);

  dqx_far_model far (.clk(CLK), .rst(RST), .adc_lat, .mem_lat,
    .adc_start(ADC_START), .adc_done(ADC_DONE), .adc_data(ADC_DATA),
    .mem_rd(MEM_RD), .mem_rd_addr(MEM_RD_ADDR), .mem_rd_valid(MEM_RD_VALID),
    .mem_rd_data(MEM_RD_DATA), .mem_wr(MEM_WR), .mem_wr_addr(MEM_WR_ADDR),
    .mem_wr_ready(MEM_WR_READY), .wr_count, .wr_last);

  // Free-running 200 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // Count conversion starts; host reader drains the FIFO when allowed
  always @(posedge CLK) begin
    if (ADC_START === 1'b1) starts <= starts + 1;
    rd_d <= FIFO_READ;
    if (rd_d === 1'b1) got.push_back(FIFO_DATA);
    FIFO_READ <= auto_rd && (DATA_AVAILABLE_FLAG === 1'b1) && !FIFO_READ
      && !rd_d;
  end

  // Interrupt level implied by the flags and their enables
  function automatic logic exp_irq();
    return (FIFO_DATA_IRQ_ENABLE & DATA_AVAILABLE_FLAG)
      | (HALF_FULL_IRQ_ENABLE & ~FIFO_HALF_FULL_N)
      | (ERROR_IRQ_ENABLE & (OVERFLOW_FLAG | OVERRUN_FLAG))
      | (ACQ_END_IRQ_ENABLE & COUNT_COUNTER_OUT);
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return ACQ_RUNNING;
      1: return DMA_BUSY;
      2: return OVERRUN_FLAG;
      default: return OVERFLOW_FLAG;
    endcase
  endfunction

  task automatic summarize();
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge CLK);
  endtask

  // Bounded wait for a status level; running out ends the run
  task automatic wt(input int w, input logic lvl, input int lim);
    int j;
    for (j = 0; j < lim; j++) begin
      @(negedge CLK);
      if (pick(w) === lvl) return;
    end
    chk("wait", 32'(lvl), 32'hFFFFFFFF);
    summarize();
  endtask

  // One pacing pulse: strobe low-going, or sample counter falling
  task automatic pace(input bit strb, input int gap);
    @(posedge CLK);
    if (strb) EXT_CONVERT_STROBE_N <= 1'b0;
    else SAMPLE_COUNTER_OUT <= 1'b1;
    cyc(2);
    if (strb) EXT_CONVERT_STROBE_N <= 1'b1;
    else SAMPLE_COUNTER_OUT <= 1'b0;
    cyc(gap);
  endtask

  task automatic pulse_clear(input bit flags);
    @(posedge CLK);
    if (flags) FLAG_CLEAR <= 1'b1;
    else FIFO_CLEAR_WR <= 1'b1;
    @(posedge CLK);
    FLAG_CLEAR <= 1'b0;
    FIFO_CLEAR_WR <= 1'b0;
  endtask

  initial begin
    {EXT_TRIGGER_IN, SCAN_PULSE_PIN, SOFT_TRIGGER_BIT, HARD_TRIGGER_ENABLE,
      PRETRIGGER_SELECT, INTERVAL_SCAN_ENABLE, EXT_SCAN_RECEIVE,
      COUNTER_A_MODE_WR, SAMPLE_COUNTER_OUT, SCAN_COUNTER_OUT, FIFO_CLEAR_WR,
      FLAG_CLEAR, FIFO_DATA_IRQ_ENABLE, HALF_FULL_IRQ_ENABLE,
      ERROR_IRQ_ENABLE, ACQ_END_IRQ_ENABLE, DMA_REQUEST_ENABLE, DMA_ARM,
      auto_rd, COUNTER_A_MODE, SCAN_SAMPLES, SAMPLE_COUNT_N,
      NEXT_LINK_ADDRESS, mem_lat} = '0;
    {EXT_CONVERT_STROBE_N, EXT_CONVERT_DISABLE, RST} = 3'h7;
    adc_lat = 8'h04;
    {err_total, checks_done, starts} = '0;
    void'($urandom(32'h4E1DB351));
    cyc(2);
    RST <= 1'b0;
    @(negedge CLK);
    chk("reset outs", 32'h1, {IRQ, DMA_REQUEST, DMA_BUSY, MEM_RD, MEM_WR,
      ACQ_RUNNING, DATA_AVAILABLE_FLAG, OVERFLOW_FLAG, OVERRUN_FLAG,
      COUNT_COUNTER_OUT, FIFO_HALF_FULL_N});
    // Posttrigger: later trigger edges must not retrigger
    @(posedge CLK);
    SAMPLE_COUNT_N <= 16'h0001;
    HARD_TRIGGER_ENABLE <= 1'b1;
    auto_rd <= 1'b1;
    cyc(2);
    EXT_TRIGGER_IN <= 1'b1;
    s0 = starts;
    wt(0, 1'b1, 4);
    for (i = 0; i < 5; i++) begin
      @(posedge CLK);
      if (i < 2) EXT_TRIGGER_IN <= ~EXT_TRIGGER_IN;
      pace(0, 8);
    end
    wt(0, 1'b0, 20);
    chk("post starts", 3, starts - s0);
    chk("count out", 1, COUNT_COUNTER_OUT);
    chk("reads", 3, got.size());
    foreach (got[k]) chk("data", k + 1, got[k]);
    @(posedge CLK);
    ACQ_END_IRQ_ENABLE <= 1'b1;
    @(negedge CLK);
    chk("irq end", 1, IRQ);
    // Early halt by hard enable low then FIFO clear
    @(posedge CLK);
    {ACQ_END_IRQ_ENABLE, auto_rd, HARD_TRIGGER_ENABLE, EXT_TRIGGER_IN} <= '0;
    cyc(2);
    HARD_TRIGGER_ENABLE <= 1'b1;
    cyc(2);
    EXT_TRIGGER_IN <= 1'b1;
    wt(0, 1'b1, 4);
    pace(0, 8);
    pace(0, 8);
    chk("dma masked", 0, DMA_REQUEST);
    chk("irq masked", 0, IRQ);
    DMA_REQUEST_ENABLE <= 1'b1;
    FIFO_DATA_IRQ_ENABLE <= 1'b1;
    @(negedge CLK);
    chk("dma req", 1, DMA_REQUEST);
    chk("irq data", 1, IRQ);
    @(posedge CLK);
    HARD_TRIGGER_ENABLE <= 1'b0;
    pulse_clear(0);
    cyc(2);
    @(negedge CLK);
    chk("flushed", 0, {DATA_AVAILABLE_FLAG, DMA_REQUEST, IRQ});
    // Strobe pacing: first strobe after start is dropped
    @(posedge CLK);
    {DMA_REQUEST_ENABLE, FIFO_DATA_IRQ_ENABLE, EXT_CONVERT_DISABLE} <= '0;
    {EXT_TRIGGER_IN, COUNTER_A_MODE_WR, SAMPLE_COUNTER_OUT} <= 3'h7;
    COUNTER_A_MODE <= MODE_A0_RATE;
    SAMPLE_COUNT_N <= 16'h0010;
    auto_rd <= 1'b1;
    @(posedge CLK);
    COUNTER_A_MODE_WR <= 1'b0;
    SOFT_TRIGGER_BIT <= 1'b1;
    s0 = starts;
    wt(0, 1'b1, 4);
    repeat (3) pace(1, 8);
    chk("strobe starts", 2, starts - s0);
    SOFT_TRIGGER_BIT <= 1'b0;
    EXT_CONVERT_DISABLE <= 1'b1;
    EXT_TRIGGER_IN <= 1'b0;
    cyc(2);
    SAMPLE_COUNTER_OUT <= 1'b0;
    // Pretrigger: soft start, trigger rise gates the final N + 1
    n = $urandom_range(3, 2);
    SAMPLE_COUNT_N <= n[15:0];
    PRETRIGGER_SELECT <= 1'b1;
    cyc(2);
    SOFT_TRIGGER_BIT <= 1'b1;
    wt(0, 1'b1, 4);
    pace(0, 8);
    pace(0, 8);
    chk("pre running", 1, ACQ_RUNNING);
    EXT_TRIGGER_IN <= 1'b1;
    s0 = starts;
    repeat (8) pace(0, 8);
    chk("pre starts", n + 1, starts - s0);
    chk("pre stop", 2'h1, {ACQ_RUNNING, COUNT_COUNTER_OUT});
    {SOFT_TRIGGER_BIT, PRETRIGGER_SELECT, EXT_TRIGGER_IN} <= '0;
    // Overrun, overflow, and the interrupt gating under random enables
    adc_lat <= 8'h28;
    SAMPLE_COUNT_N <= 16'h0100;
    cyc(2);
    SOFT_TRIGGER_BIT <= 1'b1;
    wt(0, 1'b1, 4);
    pace(0, 1);
    pace(0, 1);
    wt(2, 1'b1, 8);
    repeat (8) begin
      @(posedge CLK);
      {FIFO_DATA_IRQ_ENABLE, HALF_FULL_IRQ_ENABLE, ERROR_IRQ_ENABLE,
        ACQ_END_IRQ_ENABLE} <= 4'($urandom);
      @(negedge CLK);
      chk("irq", 32'(exp_irq()), IRQ);
    end
    cyc(50);
    pulse_clear(1);
    @(negedge CLK);
    chk("overrun clr", 0, OVERRUN_FLAG);
    adc_lat <= 8'h02;
    auto_rd <= 1'b0;
    repeat (7) pace(0, 4);
    wt(3, 1'b1, 8);
    @(posedge CLK);
    ERROR_IRQ_ENABLE <= 1'b1;
    @(negedge CLK);
    chk("irq err", 1, IRQ);
    @(posedge CLK);
    SOFT_TRIGGER_BIT <= 1'b0;
    pulse_clear(0);
    pulse_clear(1);
    // Chained DMA: two writes to the first buffer, then the zero link
    mem_lat <= 2'($urandom);
    SOFT_TRIGGER_BIT <= 1'b1;
    wt(0, 1'b1, 4);
    pace(0, 8);
    pace(0, 8);
    SOFT_TRIGGER_BIT <= 1'b0;
    DMA_REQUEST_ENABLE <= 1'b1;
    NEXT_LINK_ADDRESS <= 32'h0;
    s0 = wr_count;
    cyc(2);
    DMA_ARM <= 1'b1;
    @(posedge CLK);
    DMA_ARM <= 1'b0;
    wt(1, 1'b0, 300);
    chk("dma writes", 2, wr_count - s0);
    chk("dma addr", 32'h102, wr_last);
    chk("drained", 0, DATA_AVAILABLE_FLAG);
    // Interval scan timed by the scan pin, conversions by the strobe
    @(posedge CLK);
    {INTERVAL_SCAN_ENABLE, EXT_SCAN_RECEIVE} <= 2'h3;
    {EXT_CONVERT_DISABLE, auto_rd} <= 2'h1;
    SCAN_SAMPLES <= 8'h02;
    SOFT_TRIGGER_BIT <= 1'b1;
    s0 = starts;
    wt(0, 1'b1, 4);
    pace(1, 4);
    SCAN_PULSE_PIN <= 1'b1;
    repeat (4) pace(1, 4);
    chk("scan starts", 2, starts - s0);
    summarize();
  end
endmodule // dqx_acq_ctl_tb
